// file: pkg/dspwm_pkg.sv
package dspwm_pkg;
  // Register byte offsets
  localparam logic [7:0] DSPWM_CTRL_OFS = 8'h00;
  localparam logic [7:0] DSPWM_COUNT_OFS = 8'h04;
  localparam logic [7:0] DSPWM_CMPA_OFS = 8'h08;
  localparam logic [7:0] DSPWM_CMPB_OFS = 8'h0c;
  localparam logic [7:0] DSPWM_CAPTOP_OFS = 8'h10;
  localparam logic [7:0] DSPWM_FLAGS_OFS = 8'h14;
  localparam logic [7:0] DSPWM_STATUS_OFS = 8'h18;
  // Control field positions
  localparam int DSPWM_WGM_LSB = 0;
  localparam int DSPWM_ACTA_LSB = 4;
  localparam int DSPWM_ACTB_LSB = 6;
  localparam int DSPWM_DIRA_BIT = 8;
  localparam int DSPWM_DIRB_BIT = 9;
  localparam int DSPWM_RUN_BIT = 10;
  localparam int DSPWM_CTRL_W = 11;
  // Flag bit positions
  localparam int DSPWM_FLG_OVF = 0;
  localparam int DSPWM_FLG_CMPA = 1;
  localparam int DSPWM_FLG_CMPB = 2;
  localparam int DSPWM_FLG_CAP = 3;
  // Reset values
  localparam logic [10:0] DSPWM_CTRL_RST = 11'h000;
  localparam logic [15:0] DSPWM_WORD_RST = 16'h0000;
  // Waveform select codes
  localparam logic [3:0] DSPWM_WGM_PC8 = 4'h1;
  localparam logic [3:0] DSPWM_WGM_PC9 = 4'h2;
  localparam logic [3:0] DSPWM_WGM_PC10 = 4'h3;
  localparam logic [3:0] DSPWM_WGM_PFC_CAP = 4'h8;
  localparam logic [3:0] DSPWM_WGM_PFC_A = 4'h9;
  localparam logic [3:0] DSPWM_WGM_PC_CAP = 4'ha;
  localparam logic [3:0] DSPWM_WGM_PC_A = 4'hb;
  // Fixed tops
  localparam logic [15:0] DSPWM_TOP8 = 16'h00ff;
  localparam logic [15:0] DSPWM_TOP9 = 16'h01ff;
  localparam logic [15:0] DSPWM_TOP10 = 16'h03ff;
  localparam logic [15:0] DSPWM_TOP_MAX = 16'hffff;
  localparam logic [15:0] DSPWM_BOTTOM = 16'h0000;
  // Output actions
  localparam logic [1:0] DSPWM_ACT_OFF = 2'h0;
  localparam logic [1:0] DSPWM_ACT_TOGGLE = 2'h1;
  localparam logic [1:0] DSPWM_ACT_NONINV = 2'h2;
  localparam logic [1:0] DSPWM_ACT_INV = 2'h3;

  // Mapped word check, used by the slave for its error answer
  function automatic logic dspwm_addr_ok(input logic [7:0] a);
    dspwm_addr_ok = (a[1:0] == 2'h0) && (a <= DSPWM_STATUS_OFS);
  endfunction

  // Fixed-top value for a code, full range otherwise
  function automatic logic [15:0] dspwm_fixed_top(input logic [3:0] w);
    case (w)
      DSPWM_WGM_PC8: dspwm_fixed_top = DSPWM_TOP8;
      DSPWM_WGM_PC9: dspwm_fixed_top = DSPWM_TOP9;
      DSPWM_WGM_PC10: dspwm_fixed_top = DSPWM_TOP10;
      default: dspwm_fixed_top = DSPWM_TOP_MAX;
    endcase
  endfunction
endpackage

// file: verilog/dspwm_apb.sv
`timescale 1ns/1ps
`default_nettype none
// APB slave front end: one wait-free access phase per transfer
module dspwm_apb
  import dspwm_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] rd_data,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  output logic wr_en
);
  logic pready_reg; // Ready raised for the access phase
  logic pslverr_reg; // Unmapped address answer
  logic [31:0] prdata_reg; // Read data captured in setup
  wire setup = psel && !penable; // Setup cycle seen

  // Sample answer during setup so it stands for the access edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      pready_reg <= setup;
      pslverr_reg <= setup && !dspwm_addr_ok(paddr);
      prdata_reg <= (setup && !pwrite) ? rd_data : 32'h0000_0000;
    end
  end

  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign prdata = prdata_reg;
  // Writes land only on the completing edge, never on an error
  assign wr_en = psel && penable && pready_reg && pwrite && !pslverr_reg;
endmodule // dspwm_apb
`default_nettype wire

// file: verilog/dspwm_cmp.sv
`timescale 1ns/1ps
`default_nettype none
// One compare channel: buffer, active register and output level
module dspwm_cmp
  import dspwm_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wr_en,
  input wire logic [15:0] wr_data,
  input wire logic load,
  input wire logic buffered,
  input wire logic run,
  input wire logic [15:0] count,
  input wire logic down,
  input wire logic [15:0] top,
  input wire logic [1:0] action,
  input wire logic toggle_ok,
  output logic [15:0] cmp_buf,
  output logic [15:0] cmp_active,
  output logic match,
  output logic cmp_out
);
  logic [15:0] buf_reg; // Software-visible buffer
  logic [15:0] act_reg; // Value compared against the counter
  logic out_reg; // Compare output level
  logic out_next;
  wire inv = (action == DSPWM_ACT_INV); // Inverted polarity
  wire pwm = action[1]; // Either PWM action
  wire ext_lo = (act_reg == DSPWM_BOTTOM); // Pinned-low case
  wire ext_hi = (act_reg == top); // Pinned-high case

  assign match = run && (count == act_reg);

  // Buffer always takes the write; active follows at update point when buffered, else at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_reg <= DSPWM_WORD_RST;
      act_reg <= DSPWM_WORD_RST;
      out_reg <= 1'b0;
    end else begin
      buf_reg <= wr_en ? wr_data : buf_reg;
      if (!buffered && wr_en)
        act_reg <= wr_data;
      else if (buffered && load)
        act_reg <= buf_reg;
      out_reg <= out_next;
    end
  end

  // Level decision; extremes override the slope matches
  always_comb begin
    out_next = out_reg;
    if (run && pwm) begin
      if (ext_lo)
        out_next = inv;
      else if (ext_hi)
        out_next = !inv;
      else if (match && !down)
        out_next = inv;
      else if (match && down)
        out_next = !inv;
    end else if (action == DSPWM_ACT_TOGGLE && toggle_ok && match) begin
      out_next = !out_reg;
    end
  end

  assign cmp_buf = buf_reg;
  assign cmp_active = act_reg;
  assign cmp_out = out_reg;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  up_clear_a: assert property (
    (action == DSPWM_ACT_NONINV && match && !down && !ext_lo && !ext_hi) |=> !out_reg)
    else $error("Non-inverted output not cleared on up match");
  pin_low_a: assert property (
    (run && action == DSPWM_ACT_NONINV && ext_lo) |=> !out_reg)
    else $error("Zero compare did not hold output low");
  toggle_a: assert property (
    (action == DSPWM_ACT_TOGGLE && toggle_ok && match) |=> (out_reg != $past(out_reg)))
    else $error("Toggle on match missed");
endmodule // dspwm_cmp
`default_nettype wire

// file: verilog/dspwm_top.sv
`timescale 1ns/1ps
`default_nettype none
// Dual-slope 16-bit PWM timer with APB register access
module dspwm_top
  import dspwm_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  output logic compare_output_a,
  output logic compare_output_a_oe,
  output logic compare_output_b,
  output logic compare_output_b_oe
);
  // Register and counter state
  logic [DSPWM_CTRL_W-1:0] ctrl_reg; // Mode, actions, direction, run
  logic [15:0] count_reg; // count_value
  logic [15:0] count_next;
  logic down_reg; // Counting downward
  logic down_next;
  logic [15:0] captop_reg; // capture_top_value, not buffered
  logic [3:0] flag_reg; // Sticky event flags
  logic [3:0] flag_next;
  logic oe_a_reg; // Pin A driven
  logic oe_b_reg; // Pin B driven

  // Bus side wires
  logic wr_en;
  logic [31:0] rd_data;

  // Channel wires
  logic [15:0] cmp_a_buf;
  logic [15:0] cmp_a_act;
  logic [15:0] cmp_b_buf;
  logic [15:0] cmp_b_act;
  logic match_a;
  logic match_b;
  logic out_a;
  logic out_b;

  // Control fields
  wire [3:0] waveform_select = ctrl_reg[DSPWM_WGM_LSB +: 4];
  wire [1:0] output_action_a = ctrl_reg[DSPWM_ACTA_LSB +: 2];
  wire [1:0] output_action_b = ctrl_reg[DSPWM_ACTB_LSB +: 2];
  wire pin_direction_a = ctrl_reg[DSPWM_DIRA_BIT];
  wire pin_direction_b = ctrl_reg[DSPWM_DIRB_BIT];
  wire run_bit = ctrl_reg[DSPWM_RUN_BIT];

  // Mode decode
  wire fixed_top = (waveform_select == DSPWM_WGM_PC8) ||
                   (waveform_select == DSPWM_WGM_PC9) ||
                   (waveform_select == DSPWM_WGM_PC10);
  wire pc_mode = fixed_top || (waveform_select == DSPWM_WGM_PC_CAP) ||
                 (waveform_select == DSPWM_WGM_PC_A);
  wire pfc_mode = (waveform_select == DSPWM_WGM_PFC_CAP) ||
                  (waveform_select == DSPWM_WGM_PFC_A);
  wire top_from_a = (waveform_select == DSPWM_WGM_PC_A) ||
                    (waveform_select == DSPWM_WGM_PFC_A);
  wire top_from_cap = (waveform_select == DSPWM_WGM_PC_CAP) ||
                      (waveform_select == DSPWM_WGM_PFC_CAP);
  // Other modes are not built here, so the counter idles in them
  wire active = run_bit && (pc_mode || pfc_mode);

  // Top selection: fixed, capture register or active compare A
  wire [15:0] top_value = top_from_a ? cmp_a_act :
                          top_from_cap ? captop_reg :
                          dspwm_fixed_top(waveform_select);
  wire at_top = active && !down_reg && (count_reg >= top_value);
  wire at_bottom = active && (count_reg == DSPWM_BOTTOM);
  // Update point differs: phase correct at top, frequency correct at zero
  wire load_pt = (pc_mode && at_top) || (pfc_mode && at_bottom);

  // Write decode
  wire wr_ctrl = wr_en && (paddr == DSPWM_CTRL_OFS);
  wire wr_count = wr_en && (paddr == DSPWM_COUNT_OFS);
  wire wr_cmpa = wr_en && (paddr == DSPWM_CMPA_OFS);
  wire wr_cmpb = wr_en && (paddr == DSPWM_CMPB_OFS);
  wire wr_cap = wr_en && (paddr == DSPWM_CAPTOP_OFS);
  wire wr_flags = wr_en && (paddr == DSPWM_FLAGS_OFS);
  // High compare bits are dropped on write while a fixed top is in use
  wire [15:0] cmp_wdata = pwdata[15:0] &
                          (fixed_top ? dspwm_fixed_top(waveform_select) : DSPWM_TOP_MAX);

  // Flag sources
  wire set_ovf = (pc_mode && at_bottom) || (pfc_mode && at_bottom);
  wire set_cmpa = match_a || (top_from_a && at_top);
  wire set_cap = top_from_cap && at_top;
  wire [3:0] flag_set = {set_cap, match_b, set_cmpa, set_ovf};
  wire [3:0] flag_clr = wr_flags ? pwdata[3:0] : 4'h0;

  // Read mux, valid in the setup cycle
  assign rd_data =
    (paddr == DSPWM_CTRL_OFS) ? {21'h000000, ctrl_reg} :
    (paddr == DSPWM_COUNT_OFS) ? {16'h0000, count_reg} :
    (paddr == DSPWM_CMPA_OFS) ? {16'h0000, cmp_a_buf} :
    (paddr == DSPWM_CMPB_OFS) ? {16'h0000, cmp_b_buf} :
    (paddr == DSPWM_CAPTOP_OFS) ? {16'h0000, captop_reg} :
    (paddr == DSPWM_FLAGS_OFS) ? {28'h0000000, flag_reg} :
    (paddr == DSPWM_STATUS_OFS) ? {29'h00000000, out_b, out_a, down_reg} :
    32'h0000_0000;

  // Dual-slope counting; turns at top and at bottom without holding either value
  always_comb begin
    count_next = count_reg;
    down_next = down_reg;
    if (wr_count) begin
      count_next = pwdata[15:0];
    end else if (active) begin
      if (at_top) begin
        down_next = 1'b1;
        count_next = count_reg - 16'h0001;
      end else if (down_reg && at_bottom) begin
        down_next = 1'b0;
        count_next = count_reg + 16'h0001;
      end else if (down_reg) begin
        count_next = count_reg - 16'h0001;
      end else begin
        count_next = count_reg + 16'h0001;
      end
    end
  end

  // Hardware set wins over a software clear in the same cycle
  assign flag_next = (flag_reg & ~flag_clr) | flag_set;

  // Control and counter state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= DSPWM_CTRL_RST;
      captop_reg <= DSPWM_WORD_RST;
      count_reg <= DSPWM_WORD_RST;
      down_reg <= 1'b0;
      flag_reg <= 4'h0;
    end else begin
      ctrl_reg <= wr_ctrl ? pwdata[DSPWM_CTRL_W-1:0] : ctrl_reg;
      captop_reg <= wr_cap ? pwdata[15:0] : captop_reg;
      count_reg <= count_next;
      down_reg <= down_next;
      flag_reg <= flag_next;
    end
  end

  // Pin enables: driven only for a connected action and output direction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oe_a_reg <= 1'b0;
      oe_b_reg <= 1'b0;
    end else begin
      oe_a_reg <= pin_direction_a && (output_action_a != DSPWM_ACT_OFF);
      oe_b_reg <= pin_direction_b && (output_action_b != DSPWM_ACT_OFF);
    end
  end

  // APB slave
  dspwm_apb u_apb (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .rd_data(rd_data),
    .pready(pready),
    .pslverr(pslverr),
    .prdata(prdata),
    .wr_en(wr_en)
  );

  // Channel A; toggle allowed only when A itself sets the top
  dspwm_cmp u_cmp_a (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(wr_cmpa),
    .wr_data(cmp_wdata),
    .load(load_pt),
    .buffered(pc_mode || pfc_mode),
    .run(active),
    .count(count_reg),
    .down(down_reg),
    .top(top_value),
    .action(output_action_a),
    .toggle_ok(top_from_a),
    .cmp_buf(cmp_a_buf),
    .cmp_active(cmp_a_act),
    .match(match_a),
    .cmp_out(out_a)
  );

  // Channel B never toggles
  dspwm_cmp u_cmp_b (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(wr_cmpb),
    .wr_data(cmp_wdata),
    .load(load_pt),
    .buffered(pc_mode || pfc_mode),
    .run(active),
    .count(count_reg),
    .down(down_reg),
    .top(top_value),
    .action(output_action_b),
    .toggle_ok(1'b0),
    .cmp_buf(cmp_b_buf),
    .cmp_active(cmp_b_act),
    .match(match_b),
    .cmp_out(out_b)
  );

  assign compare_output_a = out_a;
  assign compare_output_b = out_b;
  assign compare_output_a_oe = oe_a_reg;
  assign compare_output_b_oe = oe_b_reg;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Rising slope then turn at top
  sequence rising_s;
    active && !down_reg && !at_top && !wr_count;
  endsequence
  sequence turn_s;
    active && at_top && !wr_count;
  endsequence
  // Falling slope and the turn at zero
  sequence falling_s;
    active && down_reg && !at_bottom && !wr_count;
  endsequence
  sequence bottom_s;
    active && down_reg && at_bottom && !wr_count;
  endsequence

  count_up_a: assert property (
    rising_s |=> (count_reg == $past(count_reg) + 16'h0001))
    else $error("Counter did not step up");
  top_turn_a: assert property (
    turn_s |=> down_reg && (count_reg == $past(count_reg) - 16'h0001))
    else $error("Counter did not reverse after top");
  fixed_top_a: assert property (
    (waveform_select == DSPWM_WGM_PC9) |-> (top_value == DSPWM_TOP9))
    else $error("Fixed nine-bit top wrong");
  ovf_flag_a: assert property (
    (pc_mode && at_bottom) |=> flag_reg[DSPWM_FLG_OVF])
    else $error("Overflow flag not set at zero");
  pc_load_a: assert property (
    (pc_mode && at_top) |=> (cmp_b_act == $past(cmp_b_buf)))
    else $error("Phase correct load at top missed");
  pfc_load_a: assert property (
    (pfc_mode && at_bottom && !at_top) |=> (cmp_b_act == $past(cmp_b_buf)) &&
      flag_reg[DSPWM_FLG_OVF])
    else $error("Frequency correct load at zero missed");
  cap_flag_a: assert property (
    (pfc_mode && top_from_cap && at_top) |=> flag_reg[DSPWM_FLG_CAP])
    else $error("Capture flag not set at top");
  mask_a: assert property (
    (wr_cmpb && waveform_select == DSPWM_WGM_PC8) |=> (cmp_b_buf[15:8] == 8'h00))
    else $error("Fixed top bits not masked");
  pin_oe_a: assert property (
    !pin_direction_a |=> !compare_output_a_oe)
    else $error("Pin A driven without output direction");
  pin_oe_b_a: assert property (
    !pin_direction_b |=> !compare_output_b_oe)
    else $error("Pin B driven without output direction");

  // Counter shape on the falling side and while idle
  count_down_a: assert property (
    falling_s |=> (count_reg == $past(count_reg) - 16'h0001))
    else $error("Counter did not step down");
  bottom_turn_a: assert property (
    bottom_s |=> !down_reg && (count_reg == 16'h0001))
    else $error("Counter did not reverse after zero");
  idle_hold_a: assert property (
    (!active && !wr_count) |=> (count_reg == $past(count_reg)))
    else $error("Counter moved outside a dual-slope mode");

  // Flags follow the register that defines top, and every match
  pc_cap_flag_a: assert property (
    (pc_mode && top_from_cap && at_top) |=> flag_reg[DSPWM_FLG_CAP])
    else $error("Capture flag not set at phase correct top");
  pfc_a_flag_a: assert property (
    (pfc_mode && top_from_a && at_top) |=> flag_reg[DSPWM_FLG_CMPA])
    else $error("Compare A flag not set at top");
  match_flag_a: assert property (
    match_b |=> flag_reg[DSPWM_FLG_CMPB])
    else $error("Compare B flag not set on match");

  // Extremes and toggle limits seen at the pins
  top_high_a: assert property (
    (pfc_mode && active && output_action_b == DSPWM_ACT_NONINV && cmp_b_act == top_value &&
      cmp_b_act != DSPWM_BOTTOM) |=> compare_output_b)
    else $error("Compare at top did not hold output high");
  inv_low_a: assert property (
    (pfc_mode && active && output_action_a == DSPWM_ACT_INV && cmp_a_act == DSPWM_BOTTOM)
      |=> compare_output_a)
    else $error("Inverted zero compare did not hold output high");
  b_no_toggle_a: assert property (
    (output_action_b == DSPWM_ACT_TOGGLE) |=> (compare_output_b == $past(compare_output_b)))
    else $error("Channel B toggled");
endmodule // dspwm_top
`default_nettype wire

// file: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the dual-slope PWM timer, driven over APB
module tb_top;
  import dspwm_pkg::*;
  localparam int LIMIT = 60000; // Cycle ceiling, far above the planned run
  logic pclk = 1'b0; // 40 MHz bus and timer clock
  logic presetn = 1'b0; // Held low for the first ten cycles
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic pready;
  logic pslverr;
  logic [31:0] prdata;
  logic cmp_a;
  logic cmp_a_oe;
  logic cmp_b;
  logic cmp_b_oe;
  int err_total = 0; // Mismatches seen
  int compares = 0; // Comparisons made
  int cyc = 0; // Free-running cycle count for the hang guard
  logic [31:0] rd; // Data of the last APB access
  logic er; // Error flag of the last APB access
  logic [3:0] k; // Waveform code under test
  logic [1:0] aa; // Output action, channel A
  logic [1:0] ab; // Output action, channel B
  logic [1:0] dir; // Pin direction bits, B then A
  logic ok;
  int hi, lo, tp, ca, cb, seed;
  logic [3:0] fk [4] = '{DSPWM_WGM_PC_CAP, DSPWM_WGM_PFC_CAP, DSPWM_WGM_PC_A, DSPWM_WGM_PFC_A};

  dspwm_top dspwm_top_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .compare_output_a(cmp_a), .compare_output_a_oe(cmp_a_oe),
    .compare_output_b(cmp_b), .compare_output_b_oe(cmp_b_oe)
  );

  // Clock: invert every half period
  always #12.5ns pclk = ~pclk;

  // Hang guard: a stuck wait ends the run as a failure
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      err_total++;
      $display("ERROR %0t: run exceeded cycle ceiling", $time);
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Single comparison point; four-state compare so unknowns never match
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic done_test(input string s);
    $display("test %s done", s);
  endtask

  // One APB transfer; entered just after a rising edge, holds until pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    // The slave answers in the first access cycle, with no wait state
    check(32'(n), 32'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge so the next setup never lands in the same time step
    @(posedge pclk);
  endtask

  // Stop, load top and compares directly, clear count, then start
  task automatic cfg(input logic [3:0] c, input logic [1:0] a1, input logic [1:0] b1,
                     input logic [1:0] d, input int t, input int c1, input int c2);
    apb(1'b1, DSPWM_CTRL_OFS, 32'h0);
    apb(1'b1, DSPWM_CAPTOP_OFS, 32'(t)); // top changes only while stopped
    apb(1'b1, DSPWM_CMPA_OFS, 32'(c1));
    apb(1'b1, DSPWM_CMPB_OFS, 32'(c2));
    apb(1'b1, DSPWM_COUNT_OFS, 32'h0);
    apb(1'b1, DSPWM_CTRL_OFS, {21'h0, 1'b1, d, b1, a1, c});
  endtask

  // Cycles until the chosen output shows the given level
  task automatic wait_lvl(input logic ch, input logic lvl, output int n);
    n = 0;
    while ((ch ? cmp_b : cmp_a) !== lvl && n < 2000) begin
      @(posedge pclk);
      n++;
    end
  endtask

  // High and low durations of one full output period
  task automatic duty(input logic ch, output int h, output int l);
    int n;
    wait_lvl(ch, 1'b0, n);
    wait_lvl(ch, 1'b1, n);
    wait_lvl(ch, 1'b0, h);
    wait_lvl(ch, 1'b1, l);
  endtask

  function automatic logic [15:0] fixtop(input int c);
    return c == 1 ? DSPWM_TOP8 : (c == 2 ? DSPWM_TOP9 : DSPWM_TOP10);
  endfunction

  function automatic logic act_mode(input logic [3:0] c);
    return c inside {DSPWM_WGM_PC8, DSPWM_WGM_PC9, DSPWM_WGM_PC10, DSPWM_WGM_PFC_CAP,
                     DSPWM_WGM_PFC_A, DSPWM_WGM_PC_CAP, DSPWM_WGM_PC_A};
  endfunction

  // Expected high time: non-inverted is high for twice the compare value
  function automatic int exp_hi(input logic [1:0] a, input int c, input int t);
    return a == DSPWM_ACT_NONINV ? 2 * c : 2 * (t - c);
  endfunction

  initial begin
    seed = $urandom(14);
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Every mapped word reads zero after reset; holes are refused
    for (int i = 0; i <= 24; i += 4) begin
      apb(1'b0, 8'(i), 32'h0);
      check(rd, 32'h0);
      check(er, 1'b0);
    end
    apb(1'b0, 8'h1c, 32'h0);
    check(er, 1'b1);
    check(rd, 32'h0);
    apb(1'b1, 8'h06, 32'hffff);
    check(er, 1'b1);
    done_test("reset");
    // Fixed tops trim written compare bits
    for (int i = 1; i <= 3; i++) begin
      apb(1'b1, DSPWM_CTRL_OFS, 32'(i));
      apb(1'b1, DSPWM_CMPA_OFS, 32'hffff);
      apb(1'b0, DSPWM_CMPA_OFS, 32'h0);
      check(rd, {16'h0, fixtop(i)});
    end
    done_test("mask");
    // Only the dual-slope codes make the counter move
    for (int i = 0; i < 16; i++) begin
      k = 4'(i);
      cfg(k, DSPWM_ACT_NONINV, DSPWM_ACT_NONINV, 2'b00, 64, 32, 32);
      repeat (8) @(posedge pclk);
      apb(1'b1, DSPWM_CTRL_OFS, {28'h0, k});
      apb(1'b0, DSPWM_COUNT_OFS, 32'h0);
      check(rd != 32'h0, act_mode(k));
    end
    done_test("decode");
    // Random tops, compares and polarities; compares kept below top
    repeat (8) begin
      tp = $urandom_range(40, 4);
      ca = $urandom_range(tp - 1, 1);
      cb = $urandom_range(tp - 1, 1);
      aa = 2'($urandom_range(3, 2));
      ab = 2'($urandom_range(3, 2));
      dir = 2'($urandom_range(3, 0));
      k = $urandom_range(1, 0) ? DSPWM_WGM_PC_CAP : DSPWM_WGM_PFC_CAP;
      cfg(k, aa, ab, dir, tp, ca, cb);
      @(posedge pclk);
      check(cmp_a_oe, dir[0]);
      check(cmp_b_oe, dir[1]);
      repeat (4 * tp + 8) @(posedge pclk);
      duty(1'b0, hi, lo);
      check(hi, exp_hi(aa, ca, tp));
      check(lo, 2 * tp - exp_hi(aa, ca, tp));
      duty(1'b1, hi, lo);
      check(hi, exp_hi(ab, cb, tp));
      check(lo, 2 * tp - exp_hi(ab, cb, tp));
    end
    done_test("duty");
    // Toggle with top taken from compare A gives equal halves
    for (int i = 2; i < 4; i++) begin
      tp = $urandom_range(20, 4);
      cfg(fk[i], DSPWM_ACT_TOGGLE, DSPWM_ACT_OFF, 2'b11, tp, tp, 0);
      @(posedge pclk);
      check(cmp_b_oe, 1'b0);
      repeat (4 * tp + 8) @(posedge pclk);
      duty(1'b0, hi, lo);
      check(hi, 2 * tp);
      check(lo, 2 * tp);
    end
    done_test("toggle");
    // Compare at zero and at top hold the output steady
    for (int i = 0; i < 4; i++) begin
      tp = $urandom_range(30, 4);
      aa = i[0] ? DSPWM_ACT_INV : DSPWM_ACT_NONINV;
      cfg(fk[i / 2], aa, aa, 2'b11, tp, 0, tp);
      repeat (4 * tp + 8) @(posedge pclk);
      ok = 1'b1;
      repeat (2 * tp + 4) begin
        @(posedge pclk);
        if (cmp_a !== i[0] || cmp_b !== !i[0]) begin
          ok = 1'b0;
        end
      end
      check(ok, 1'b1);
    end
    done_test("extremes");
    // Flags: overflow at zero, top flag from the register defining top
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, DSPWM_CTRL_OFS, 32'h0);
      apb(1'b1, DSPWM_FLAGS_OFS, 32'hf);
      cfg(fk[i], DSPWM_ACT_NONINV, DSPWM_ACT_NONINV, 2'b00, 5, (i >= 2) ? 5 : 2, 2);
      repeat (30) @(posedge pclk);
      apb(1'b1, DSPWM_CTRL_OFS, {28'h0, fk[i]});
      apb(1'b0, DSPWM_FLAGS_OFS, 32'h0);
      check(rd[DSPWM_FLG_OVF], 1'b1);
      check(rd[DSPWM_FLG_CAP], i < 2);
      check(rd[DSPWM_FLG_CMPA], 1'b1);
      apb(1'b1, DSPWM_FLAGS_OFS, 32'hf);
      apb(1'b0, DSPWM_FLAGS_OFS, 32'h0);
      check(rd[3:0], 4'h0);
    end
    done_test("flags");
    print_verdict();
  end
endmodule // tb_top
`default_nettype wire
